// ===== bus_info_options.sv
`timescale 1ns/10ps
module bus_info_options (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic SOFT_RST,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic ROM_READ,
	output logic [31:0] ROM_QUADLET,
	input wire logic ROM_CHANGED,
	input wire logic BUS_RESET,
	input wire logic BLK_WRITE,
	input wire logic [15:0] BLK_LENGTH,
	output logic ACK_TYPE_ERROR
);
	typedef struct packed {
		logic [31:0] opts;
		logic changed;
		logic [31:0] rdata;
		logic [31:0] rom_q;
		logic ack_err;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic too_long;
	logic [31:0] view;

	len_check u_len (
		.max_rec(s_reg.opts[15:12]),
		.data_length(BLK_LENGTH),
		.too_long(too_long)
	);

	always_comb begin
		view = s_reg.opts & bus_info_pkg::WRITE_MASK;
		view[2:0] = bus_info_pkg::LINK_SPEED_CODE;
	end

	always_comb begin
		s_next = s_reg;
		s_next.rdata = 32'h0000_0000;
		if (WR && ADDR == bus_info_pkg::OFS_BUS_INFO_OPTIONS) begin
			s_next.opts = WDATA & bus_info_pkg::WRITE_MASK;
		end
		if (ROM_CHANGED) begin
			s_next.changed = 1'b1;
		end
		if (BUS_RESET) begin
			if (s_reg.changed || ROM_CHANGED) begin
				s_next.opts[7:6] = s_next.opts[7:6] + 2'h1;
			end
			s_next.changed = 1'b0;
		end
		if (RD && ADDR == bus_info_pkg::OFS_BUS_INFO_OPTIONS) begin
			s_next.rdata = view;
		end
		if (ROM_READ) begin
			s_next.rom_q = view;
		end
		s_next.ack_err = BLK_WRITE && too_long;
		if (SOFT_RST) begin
			s_next.opts[27] = 1'b0;
			s_next.ack_err = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			s_reg <= '0;
			s_reg.opts[15:12] <= bus_info_pkg::MAX_REC_HARD_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign RDATA = s_reg.rdata;
	assign ROM_QUADLET = s_reg.rom_q;
	assign ACK_TYPE_ERROR = s_reg.ack_err;

	AST_HARD_RESET_MAXREC: assert property (@(posedge CLK_SYS)
		$past(SYS_RST) |-> s_reg.opts[15:12] == 4'hA)
		else $error("max request not 2048 after hard reset");
	AST_SOFT_KEEP: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		$past(SOFT_RST) && !$past(WR) |-> $stable(s_reg.opts[15:12]))
		else $error("max request changed by soft reset");
	AST_PMC_SOFT: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		SOFT_RST |=> !s_reg.opts[27])
		else $error("pmc not cleared");
	AST_RESERVED_ZERO: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		RD |=> RDATA[26:24] == 3'h0 && RDATA[11:8] == 4'h0)
		else $error("reserved bits nonzero");
	AST_SPEED: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		RD && ADDR == 8'h20 |=> RDATA[5:0] == 6'h02)
		else $error("link speed wrong");
	AST_WRITE_READ: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		WR && ADDR == 8'h20 && !SOFT_RST && !BUS_RESET ##1 RD && ADDR == 8'h20
		|=> RDATA[31:12] == ($past(WDATA, 2) & 32'hF8FFF000) >> 12)
		else $error("readback mismatch");
	AST_ROM_MATCH: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		ROM_READ && RD && ADDR == 8'h20 |=> ROM_QUADLET == RDATA)
		else $error("rom quadlet differs from register");
	AST_TYPE_ERR: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		BLK_WRITE && !SOFT_RST && BLK_LENGTH <= 16'h0200 |=> !ACK_TYPE_ERROR)
		else $error("spurious type error");
	AST_GEN: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		ROM_CHANGED && BUS_RESET && !WR |=> s_reg.opts[7:6] == $past(s_reg.opts[7:6]) + 2'h1)
		else $error("generation not advanced");

	COV_WRITE: cover property (@(posedge CLK_SYS) WR && ADDR == 8'h20);
	COV_ROM: cover property (@(posedge CLK_SYS) ROM_READ);
	COV_ERR: cover property (@(posedge CLK_SYS) ACK_TYPE_ERROR);
endmodule // bus_info_options

// ===== bus_info_pkg.sv
package bus_info_pkg;
	localparam logic [7:0] OFS_BUS_INFO_OPTIONS = 8'h20;
	localparam int ADDR_W = 8;
	localparam logic [31:0] WRITE_MASK = 32'hF8FF_F0C0;
	localparam logic [3:0] MAX_REC_HARD_RESET = 4'hA;
	localparam logic [3:0] MAX_REC_MIN = 4'h8;
	localparam logic [2:0] LINK_SPEED_CODE = 3'h2;
	localparam logic [27:0] FLAGS_RESET = 28'h0000000;
	localparam int MAX_REC_LSB = 12;
	localparam int GEN_LSB = 6;
	localparam logic [16:0] BYTES_ONE = 17'h00001;

	// code 15 means 65536 bytes, so result and shift count need a spare bit
	function automatic logic [16:0] max_rec_bytes(input logic [3:0] code);
		max_rec_bytes = BYTES_ONE << ({1'h0, code} + 5'h01);
	endfunction
endpackage

// ===== len_check.sv
`timescale 1ns/10ps
module len_check (
	input wire logic [3:0] max_rec,
	input wire logic [15:0] data_length,
	output logic too_long
);
	always_comb begin
		too_long = {1'h0, data_length} >
			bus_info_pkg::max_rec_bytes(max_rec);
	end
endmodule // len_check

// ===== remote_node.sv
`timescale 1ns/10ps
module remote_node (
	input wire logic clk,
	output logic rom_read,
	output logic blk_write,
	output logic [15:0] blk_length
);
	initial begin
		rom_read = 1'b0;
		blk_write = 1'b0;
		blk_length = 16'hFFFF;
	end
	// one-cycle rom read or block write, length scrambled after
	task automatic req(input logic blk, input logic [15:0] len);
		rom_read <= !blk;
		blk_write <= blk;
		blk_length <= len;
		@(posedge clk);
		rom_read <= 1'b0;
		blk_write <= 1'b0;
		blk_length <= ~len;
	endtask
endmodule // remote_node

// ===== test_bus_info_options.sv
`timescale 1ns/10ps
module test_bus_info_options;
	logic clk = 0, rst = 1, srst = 0, wr = 0, rd = 0, chg = 0, brst = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, romq, m, d;
	logic rom_rd, blk, ack;
	logic [15:0] len, bl;
	int fails = 0, n_tests = 0;
	always #50 clk = ~clk;
	remote_node rn (.clk(clk), .rom_read(rom_rd), .blk_write(blk),
		.blk_length(len));
	bus_info_options dut (.CLK_SYS(clk), .SYS_RST(rst), .SOFT_RST(srst),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.ROM_READ(rom_rd), .ROM_QUADLET(romq), .ROM_CHANGED(chg),
		.BUS_RESET(brst), .BLK_WRITE(blk), .BLK_LENGTH(len),
		.ACK_TYPE_ERROR(ack));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= v;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clk) chk(rdata, e);
		@(posedge clk);
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(618));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		m = 32'h0000A002;
		rdchk(8'h20, m);
		rdchk(8'h24, 32'h0);
		repeat (20) begin
			d = $urandom;
			d[15] = 1'b1;
			bus(1'b1, 8'h20, d);
			m = d & 32'hF8FFF0C0 | 32'h2;
			rdchk(8'h20, m);
			rn.req(1'b0, 16'h0);
			@(negedge clk) chk(romq, m);
			bl = 16'($urandom_range(0, 4200));
			@(posedge clk) rn.req(1'b1, bl);
			@(negedge clk) chk({31'h0, ack}, {31'h0, bl > (2 << m[15:12])});
			@(posedge clk);
		end
		srst <= 1'b1;
		@(posedge clk) srst <= 1'b0;
		m[27] = 1'b0;
		rdchk(8'h20, m);
		chg <= 1'b1;
		@(posedge clk) chg <= 1'b0;
		brst <= 1'b1;
		@(posedge clk) brst <= 1'b0;
		m[7:6] = m[7:6] + 2'h1;
		rdchk(8'h20, m);
		rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		rdchk(8'h20, 32'h0000A002);
		tally_and_finish;
	end
endmodule // test_bus_info_options
